// >>> design/sar_converter.sv
// successive approximation control for the shared analog input converter
`timescale 1ns/1ps
module sar_converter
	import thermal_adc_pkg::*;
#(
	parameter int WIDTH = ADC_BITS
) (
	input wire logic clk, // system clock
	input wire logic rst, // synchronous reset
	input wire logic start, // begin one conversion
	input wire logic compHigh, // comparator: sample at or above trial level
	output logic sampleSwitchSelect, // high while sampling input
	output logic comparatorBalanceSwitch, // high while comparator held balanced
	output logic [WIDTH-1:0] trialCode, // capacitor dac trial code
	output logic busy, // conversion in progress
	output logic done, // one-cycle result pulse
	output logic [WIDTH-1:0] result // straight binary result
);
	// refused at elaboration: the acquire counter is three bits wide
	if (WIDTH < 2 || WIDTH > 16 || ACQ_CYCLES < 1 || ACQ_CYCLES > 8) begin : g_bad_width
		$error("sar width or acquire length unsupported");
	end

	typedef struct packed {
		adcState_t state;
		logic [WIDTH-1:0] code;
		logic [WIDTH-1:0] bitMask;
		logic [WIDTH-1:0] res;
		logic [2:0] acqCount;
	} sarState_t;

	sarState_t cur, next_cur;

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	always_comb begin
		next_cur = cur;
		case (cur.state)
			ADC_IDLE: begin
				if (start) begin
					next_cur.state = ADC_ACQUIRE;
					next_cur.acqCount = '0;
				end
			end
			ADC_ACQUIRE: begin
				next_cur.acqCount = cur.acqCount + 3'h1;
				if (cur.acqCount == 3'(ACQ_CYCLES - 1)) begin
					next_cur.state = ADC_CONVERT;
					next_cur.bitMask = {1'b1, {(WIDTH-1){1'b0}}};
					next_cur.code = {1'b1, {(WIDTH-1){1'b0}}};
				end
			end
			ADC_CONVERT: begin
				// comparator is assumed offset by half a step, so kept bits round to nearest
				next_cur.code = compHigh ? cur.code : (cur.code & ~cur.bitMask);
				next_cur.bitMask = cur.bitMask >> 1;
				if (cur.bitMask[0]) begin
					next_cur.state = ADC_DONE;
					next_cur.res = compHigh ? cur.code : (cur.code & ~cur.bitMask);
				end else begin
					next_cur.code = (compHigh ? cur.code : (cur.code & ~cur.bitMask)) | (cur.bitMask >> 1);
				end
			end
			ADC_DONE: begin
				next_cur.state = ADC_IDLE;
			end
			default: next_cur.state = ADC_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	assign sampleSwitchSelect = (cur.state == ADC_ACQUIRE);
	assign comparatorBalanceSwitch = (cur.state == ADC_ACQUIRE) || (cur.state == ADC_IDLE);
	assign trialCode = cur.code;
	assign busy = (cur.state != ADC_IDLE);
	assign done = (cur.state == ADC_DONE);
	assign result = cur.res;

	a_done_after_acq: assert property (@(posedge clk) disable iff (rst)
		(cur.state == ADC_IDLE && start) |-> ##(ACQ_CYCLES + WIDTH + 1) done)
		else $error("conversion did not finish on time");
	// repetition count is ACQ_CYCLES written out; the sample switch then releases the balance
	a_balance_in_acq: assert property (@(posedge clk) disable iff (rst)
		$rose(sampleSwitchSelect) |-> (sampleSwitchSelect && comparatorBalanceSwitch)[*4]
			##1 (!sampleSwitchSelect && !comparatorBalanceSwitch))
		else $error("acquire phase length or balance wrong");
endmodule // sar_converter

// >>> design/thermal_adc_ctrl.sv
// register file, thermal dac mapping and analog input channel control
`timescale 1ns/1ps
module thermal_adc_ctrl
	import thermal_adc_pkg::*;
#(
	parameter int CHANNELS = 4
) (
	input wire logic clk, // system clock, 10 MHz
	input wire logic rst, // synchronous reset
	input wire logic regWrite, // register write strobe from serial interface
	input wire logic [7:0] regAddr, // register address
	input wire logic [7:0] regWdata, // write data
	output logic [7:0] regRdata, // read data for regAddr
	input wire logic tempValid, // one-cycle: new temperature measured
	input wire logic [9:0] tempMeasured, // twos complement, quarter degrees
	output logic [9:0] thermalCode, // thermal dac code
	input wire logic adcStart, // start conversion of selected channel
	input wire logic [1:0] adcChannel, // channel to convert
	input wire logic compHigh, // comparator output
	output logic inputReferenceSelect, // 0 internal reference, 1 supply
	output logic [1:0] sharedPinInputEnable, // pins used as first, second inputs
	output logic [1:0] muxSelect, // input multiplexer channel
	output logic sampleSwitchSelect, // sample switch position
	output logic comparatorBalanceSwitch, // comparator balance switch
	output logic [9:0] trialCode, // capacitor dac trial
	output logic adcBusy, // conversion running
	output logic adcDone, // one-cycle result strobe
	output logic [9:0] ainResult // last result
);
	if (CHANNELS != 4) begin : g_bad_channels
		$error("four analog channels required");
	end

	typedef struct packed {
		regFile_t regs;
		logic [9:0] dacCode;
		logic [1:0] channel;
	} ctrlState_t;

	ctrlState_t cur, next_cur;
	logic [10:0] offsetQuarter;
	logic [10:0] diff;
	logic [9:0] mapped;

	// ------------------------------------------------------------
	// thermal mapping
	// ------------------------------------------------------------
	function automatic logic [10:0] offset_to_quarter(input logic [7:0] off);
		// offset byte is twos complement whole degrees
		return {off[7], off, 2'b00};
	endfunction

	always_comb begin
		offsetQuarter = offset_to_quarter(cur.regs.tempOffset);
		diff = {tempMeasured[9], tempMeasured} - offsetQuarter;
		mapped = '0;
		if (diff[10]) begin
			mapped = '0;
		end else if (cur.regs.configThree[BIT_FINE_RES]) begin
			mapped = diff[9:0];
		end else if (diff[9:2] > COARSE_FULL[7:0]) begin
			mapped = COARSE_FULL;
		end else begin
			mapped = {2'b00, diff[9:2]};
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_comb begin
		next_cur = cur;
		if (regWrite) begin
			if (regAddr == ADDR_CONFIG_ONE) begin
				next_cur.regs.configOne = regWdata;
			end else if (regAddr == ADDR_CONFIG_THREE) begin
				next_cur.regs.configThree = regWdata;
			end else if (regAddr == ADDR_TEMP_OFFSET) begin
				next_cur.regs.tempOffset = regWdata;
			end
		end
		if (tempValid) begin
			next_cur.dacCode = mapped;
		end
		if (adcStart && !adcBusy) begin
			next_cur.channel = adcChannel;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cur.regs.configOne <= RESET_CONFIG;
			cur.regs.configThree <= RESET_CONFIG;
			cur.regs.tempOffset <= RESET_OFFSET;
			cur.dacCode <= '0;
			cur.channel <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	always_comb begin
		if (regAddr == ADDR_CONFIG_ONE) begin
			regRdata = cur.regs.configOne;
		end else if (regAddr == ADDR_CONFIG_THREE) begin
			regRdata = cur.regs.configThree;
		end else if (regAddr == ADDR_TEMP_OFFSET) begin
			regRdata = cur.regs.tempOffset;
		end else begin
			regRdata = 8'h00;
		end
	end

	assign thermalCode = cur.dacCode;
	assign inputReferenceSelect = cur.regs.configThree[BIT_REF_SEL];
	assign sharedPinInputEnable = cur.regs.configOne[BIT_PIN_HI:BIT_PIN_LO];
	assign muxSelect = cur.channel;

	// ------------------------------------------------------------
	// shared converter
	// ------------------------------------------------------------
	sar_converter #(.WIDTH(ADC_BITS)) u_sar (
		.clk(clk),
		.rst(rst),
		.start(adcStart),
		.compHigh(compHigh),
		.sampleSwitchSelect(sampleSwitchSelect),
		.comparatorBalanceSwitch(comparatorBalanceSwitch),
		.trialCode(trialCode),
		.busy(adcBusy),
		.done(adcDone),
		.result(ainResult)
	);

	// a code taken in fine mode stands until the next measurement, so only coarse updates are checked
	a_coarse_saturate: assert property (@(posedge clk) disable iff (rst)
		(tempValid && !cur.regs.configThree[BIT_FINE_RES]) |=> thermalCode <= COARSE_FULL)
		else $error("coarse code above full scale");
	a_refresh_on_temp: assert property (@(posedge clk) disable iff (rst)
		tempValid |=> thermalCode == $past(mapped))
		else $error("thermal code not refreshed");
	a_hold_no_temp: assert property (@(posedge clk) disable iff (rst)
		!tempValid |=> $stable(thermalCode))
		else $error("thermal code moved without measurement");
	a_below_clamp: assert property (@(posedge clk) disable iff (rst)
		(tempValid && diff[10]) |=> thermalCode == 10'h000)
		else $error("code not clamped below offset");
	a_fine_quarter: assert property (@(posedge clk) disable iff (rst)
		(tempValid && !diff[10] && cur.regs.configThree[BIT_FINE_RES]) |=> thermalCode == $past(diff[9:0]))
		else $error("fine mode code wrong");
	a_ref_follows: assert property (@(posedge clk) disable iff (rst)
		(regWrite && regAddr == ADDR_CONFIG_THREE) |=> inputReferenceSelect == $past(regWdata[BIT_REF_SEL]))
		else $error("reference select not updated");
	a_pin_follows: assert property (@(posedge clk) disable iff (rst)
		(regWrite && regAddr == ADDR_CONFIG_ONE) |=> sharedPinInputEnable == $past(regWdata[2:1]))
		else $error("pin assignment not updated");
	a_reset_offset: assert property (@(posedge clk)
		rst |=> cur.regs.tempOffset == RESET_OFFSET)
		else $error("offset reset value wrong");
endmodule // thermal_adc_ctrl

// >>> design/thermal_adc_pkg.sv
// constants and types for thermal dac mapping and analog input conversion
// ------------------------------------------------------------
// Behaviour
// ------------------------------------------------------------
// Behaviour
// - negative offset stored as temperature plus 128 with top bit set; positive as magnitude.
// - coarse mode code equals measured temperature minus offset, one step per degree.
// - fine mode code counts quarter degrees above the offset temperature.
// - above the span the thermal code holds at full scale, an upper deadband.
// - default offset maps code zero to minus forty; widest maps to minus 128.
// - four single-ended analog channels share one converter.
// - reference select bit at 0x1A: zero internal reference, one supply.
// - two-bit field at 0x18 assigns two shared pins as first and second inputs.
// - converter result is ten bits, step equals reference over 1024.
// - analog input results are straight binary.
// - code transitions sit at half steps, rounding to nearest.
// - acquisition samples input, then successive approximation balances the comparator.
// - offset register is eight bits, twos complement, one degree resolution.
// - thermal code is refreshed on every completed temperature measurement.
// - resolution defaults coarse; resolution bit in config three selects fine.
package thermal_adc_pkg;
	localparam logic [7:0] ADDR_CONFIG_ONE = 8'h18;
	localparam logic [7:0] ADDR_CONFIG_THREE = 8'h1A;
	localparam logic [7:0] ADDR_TEMP_OFFSET = 8'h21;
	localparam logic [7:0] RESET_CONFIG = 8'h00;
	localparam logic [7:0] RESET_OFFSET = 8'hD8;
	localparam int BIT_FINE_RES = 1;
	localparam int BIT_REF_SEL = 4;
	localparam int BIT_PIN_LO = 1;
	localparam int BIT_PIN_HI = 2;
	localparam int ADC_BITS = 10;
	localparam int ACQ_CYCLES = 4;
	localparam logic [9:0] COARSE_FULL = 10'h0FF;
	localparam logic [9:0] FINE_FULL = 10'h3FF;

	typedef enum logic [1:0] {ADC_IDLE, ADC_ACQUIRE, ADC_CONVERT, ADC_DONE} adcState_t;

	typedef struct packed {
		logic [7:0] configOne;
		logic [7:0] configThree;
		logic [7:0] tempOffset;
	} regFile_t;
endpackage

// >>> sim/comp_model.sv
// comparator stand-in for the analog front end of the input converter
`timescale 1ns/1ps
module comp_model (
	input wire logic [9:0] trialCode, // trial level from the converter
	input wire logic [9:0] level, // input already scaled to code steps
	output logic compHigh // sample at or above the trial level
);
	// the half-step offset is folded into level, so balance lands on the nearest code
	assign compHigh = (level >= trialCode);
endmodule // comp_model

// >>> sim/thermal_dac_map_and_ain_adc_tb_top.sv
// self-checking bench for thermal dac mapping and analog input control
`timescale 1ns/1ps
module thermal_dac_map_and_ain_adc_tb_top;
	import thermal_adc_pkg::*;
	logic clk, rst, regWrite, tempValid, adcStart, compHigh, inputReferenceSelect;
	logic sampleSwitchSelect, comparatorBalanceSwitch, adcBusy, adcDone;
	logic [7:0] regAddr, regWdata, regRdata, offByte;
	logic [9:0] tempMeasured, thermalCode, trialCode, ainResult, level;
	logic [1:0] adcChannel, sharedPinInputEnable, muxSelect;
	int failures = 0;
	int checks = 0;
	int offTemps[4] = '{-40, 10, -128, 0};
	int temps[6];
	int n;
	thermal_adc_ctrl i_thermal_adc_ctrl (.clk(clk), .rst(rst), .regWrite(regWrite), .regAddr(regAddr),
		.regWdata(regWdata), .regRdata(regRdata), .tempValid(tempValid), .tempMeasured(tempMeasured),
		.thermalCode(thermalCode), .adcStart(adcStart), .adcChannel(adcChannel), .compHigh(compHigh),
		.inputReferenceSelect(inputReferenceSelect), .sharedPinInputEnable(sharedPinInputEnable),
		.muxSelect(muxSelect), .sampleSwitchSelect(sampleSwitchSelect),
		.comparatorBalanceSwitch(comparatorBalanceSwitch), .trialCode(trialCode), .adcBusy(adcBusy),
		.adcDone(adcDone), .ainResult(ainResult));
	comp_model i_comp_model (.trialCode(trialCode), .level(level), .compHigh(compHigh));
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task chk(input logic [9:0] got, input logic [9:0] want);
		checks++;
		if (got !== want) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask
	task wrap_up;
		$display("checks=%0d failures=%0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		regWrite <= 1'h1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk);
		regWrite <= 1'h0;
		// let the register update settle before callers look at outputs
		#1;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] want);
		@(posedge clk);
		regAddr <= a;
		#1;
		chk(10'(regRdata), 10'(want));
	endtask
	// coarse mode truncates quarter degrees; both modes clamp at zero and full scale
	function automatic logic [9:0] model(int t, int off, bit fine);
		int d;
		d = t - off * 4;
		if (d < 0) return 10'h000;
		if (fine) return (d > 1023) ? 10'h3FF : 10'(d);
		return ((d >> 2) > 255) ? 10'h0FF : 10'(d >> 2);
	endfunction
	task tmp(input int t, input logic [9:0] want);
		@(posedge clk);
		tempValid <= 1'h1;
		tempMeasured <= 10'(t);
		@(posedge clk);
		tempValid <= 1'h0;
		#1;
		chk(thermalCode, want);
	endtask
	task conv(input logic [1:0] ch, input logic [9:0] lv);
		@(posedge clk);
		adcStart <= 1'h1;
		adcChannel <= ch;
		level <= lv;
		@(posedge clk);
		adcStart <= 1'h0;
		n = 1;
		while (n < 40) begin
			@(posedge clk);
			#1;
			if (n == 2) chk(10'({adcBusy, sampleSwitchSelect, comparatorBalanceSwitch}), 10'h007);
			if (n == ACQ_CYCLES + 1) chk(10'({adcBusy, sampleSwitchSelect, comparatorBalanceSwitch}), 10'h004);
			if (adcDone === 1'h1) break;
			n++;
		end
		// done is launched by the edge ACQ_CYCLES + ADC_BITS after the start edge
		if (n >= 40) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, n, ACQ_CYCLES + ADC_BITS);
		end else begin
			chk(10'(n), 10'(ACQ_CYCLES + ADC_BITS));
			chk(10'(muxSelect), 10'(ch));
			chk(ainResult, lv);
		end
	endtask
	// ------------------------------------------------------------
	// stimulus
	// ------------------------------------------------------------
	initial begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end
	initial begin
		rst = 1'h1;
		regWrite = 1'h0;
		regAddr = 8'h00;
		regWdata = 8'h00;
		tempValid = 1'h0;
		tempMeasured = 10'h000;
		adcStart = 1'h0;
		adcChannel = 2'h0;
		level = 10'h000;
		void'($urandom(32'hA549));
		repeat (3) @(posedge clk);
		rst <= 1'h0;
		rd(ADDR_CONFIG_THREE, 8'h00);
		rd(ADDR_TEMP_OFFSET, 8'hD8);
		tmp(-160, 10'h000);
		wr(8'h55, 8'hA5);
		rd(8'h55, 8'h00);
		wr(ADDR_CONFIG_ONE, 8'h06);
		chk(10'(sharedPinInputEnable), 10'h003);
		wr(ADDR_CONFIG_ONE, 8'h02);
		chk(10'(sharedPinInputEnable), 10'h001);
		for (int i = 0; i < 4; i++) begin
			offByte = (offTemps[i] < 0) ? (8'(offTemps[i] + 128) | 8'h80) : 8'(offTemps[i]);
			if (i > 0) wr(ADDR_TEMP_OFFSET, offByte);
			rd(ADDR_TEMP_OFFSET, offByte);
			for (int f = 0; f < 2; f++) begin
				wr(ADDR_CONFIG_THREE, 8'((f << BIT_FINE_RES) | (i % 2 << BIT_REF_SEL)));
				chk(10'(inputReferenceSelect), 10'(i % 2));
				temps = '{-512, offTemps[i] * 4, offTemps[i] * 4 + 3, offTemps[i] * 4 + 4, 511,
					int'($urandom_range(1023)) - 512};
				foreach (temps[k]) tmp(temps[k], model(temps[k], offTemps[i], f[0]));
			end
		end
		conv(2'h0, 10'h000);
		conv(2'h1, 10'h3FF);
		conv(2'h2, 10'h200);
		conv(2'h3, 10'($urandom_range(1023)));
		wrap_up();
	end
endmodule // thermal_dac_map_and_ain_adc_tb_top
